// ===== hdl/hsis_pkg.sv
// Purpose: Shared constants and types of the homing sequencer
// Assumes: 32-bit AXI4-Lite register file, byte addresses
// Notes:   Offsets, CTRL and CFG field positions and reset values live here; STAT fields are packed in hsis_top
package hsis_pkg;

  // Register byte offsets
  localparam logic [7:0] HSIS_OFF_CTRL = 8'h00;
  localparam logic [7:0] HSIS_OFF_CFG  = 8'h04;
  localparam logic [7:0] HSIS_OFF_SLOW = 8'h08;
  localparam logic [7:0] HSIS_OFF_FAST = 8'h0C;
  localparam logic [7:0] HSIS_OFF_STAT = 8'h10;
  localparam logic [7:0] HSIS_OFF_HPOS = 8'h14;

  // Control register fields
  localparam int HSIS_CTRL_START = 0;
  localparam int HSIS_CTRL_ABORT = 1;

  // Configuration register fields
  localparam int HSIS_CFG_DIR    = 0;  // 1 = right / positive
  localparam int HSIS_CFG_FAST   = 1;  // 1 = faster initial speed
  localparam int HSIS_CFG_METH   = 2;  // Two bits
  localparam int HSIS_CFG_ABS    = 4;  // Absolute encoder mode
  localparam int HSIS_CFG_SEL    = 8;  // Three bits, switch input
  localparam int HSIS_CFG_INV    = 11; // Invert switch input

  // Digital input bank
  localparam int HSIS_NDIN  = 8;
  localparam int HSIS_SEL_W = 3;

  // Reset values
  localparam logic [31:0] HSIS_CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] HSIS_SLOW_RST = 32'h0000_0100;
  localparam logic [31:0] HSIS_FAST_RST = 32'h0000_1000;

  // Bus responses
  localparam logic [1:0] HSIS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] HSIS_RESP_SLVERR = 2'h2;

  // Search methods
  typedef enum logic [1:0] {
    HSIS_M_INDEX    = 2'h0,
    HSIS_M_SWITCH   = 2'h1,
    HSIS_M_SW_IDX_L = 2'h2,
    HSIS_M_SW_IDX_R = 2'h3
  } hsis_method_t;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    HSIS_S_IDLE  = 3'h1,
    HSIS_S_FIRST = 3'h2,
    HSIS_S_FINE  = 3'h4
  } hsis_state_t;

endpackage

// ===== hdl/hsis_sense_if.sv
// Purpose: Carries switch selection and detected events
// Assumes: One clock domain
// Notes:   Sense end drives levels, sequencer end drives selection
`timescale 1ns/1ps
`default_nettype none
interface hsis_sense_if;
  import hsis_pkg::*;
  logic [HSIS_SEL_W-1:0] sel;
  logic                  inv;
  logic                  sw_lvl;
  logic                  idx_hit;
  modport sense (input sel, input inv, output sw_lvl, output idx_hit);
  modport seq   (output sel, output inv, input sw_lvl, input idx_hit);
endinterface
`default_nettype wire

// ===== hdl/hsis_sense.sv
// Purpose: Picks the home switch input and finds index rising edges
// Assumes: Inputs synchronous to mclk_i
// Notes:   Both outputs are registered, one cycle behind the pins
`timescale 1ns/1ps
`default_nettype none
module hsis_sense
  import hsis_pkg::*;
(
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  input  wire logic [HSIS_NDIN-1:0] din_i,
  input  wire logic                 index_i,
  hsis_sense_if.sense               sn
);

  logic idx_prev;
  wire  pick = din_i[sn.sel] ^ sn.inv;  // Selected input, polarity fixed

  // Switch level and index edge registers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sn.sw_lvl  <= 1'b0;
      sn.idx_hit <= 1'b0;
      idx_prev   <= 1'b0;
    end else if (ce_i) begin
      sn.sw_lvl  <= pick;
      sn.idx_hit <= index_i & ~idx_prev;
      idx_prev   <= index_i;
    end
  end

  // Switch follows the chosen input, index gives one-cycle hits
  a_switch_input_pick: assert property (
    @(posedge mclk_i) disable iff (rst_i || !ce_i)
    ce_i |=> sn.sw_lvl == $past(pick))
    else $error("switch level does not follow selected input");

  a_index_hit_single: assert property (
    @(posedge mclk_i) disable iff (rst_i || !ce_i)
    sn.idx_hit |=> !sn.idx_hit)
    else $error("index hit longer than one cycle");

endmodule // hsis_sense
`default_nettype wire

// ===== hdl/hsis_top.sv
// Purpose: Homing sequencer with switch, index and absolute modes
// Assumes: AXI4-Lite register access, inputs synchronous to mclk_i
// Notes:   speed_o is a magnitude, dir_o gives its sign
// Contract
// - The first search moves in the configured initial direction.
// - The first search runs at the slower or faster configured speed.
// - Index-only search waits for the index pulse and ignores the switch.
// - Switch-only search ends on assertion of the home switch.
// - Switch-then-left method goes slow and left to the next index.
// - Switch-then-right method goes slow and right to the next index.
// - The home switch is a selectable, invertible digital input.
// - The first phase uses both initial direction and initial speed.
// - Fast-left setup runs negative fast to the switch, then slow.
// - Absolute mode takes the present position as home, no motion.
`timescale 1ns/1ps
`default_nettype none
module hsis_top
  import hsis_pkg::*;
#(
  parameter int PW = 32
)(
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  input  wire logic [7:0]           s_axi_awaddr_i,
  input  wire logic                 s_axi_awvalid_i,
  output logic                      s_axi_awready_o,
  input  wire logic [31:0]          s_axi_wdata_i,
  input  wire logic [3:0]           s_axi_wstrb_i,
  input  wire logic                 s_axi_wvalid_i,
  output logic                      s_axi_wready_o,
  output logic [1:0]                s_axi_bresp_o,
  output logic                      s_axi_bvalid_o,
  input  wire logic                 s_axi_bready_i,
  input  wire logic [7:0]           s_axi_araddr_i,
  input  wire logic                 s_axi_arvalid_i,
  output logic                      s_axi_arready_o,
  output logic [31:0]               s_axi_rdata_o,
  output logic [1:0]                s_axi_rresp_o,
  output logic                      s_axi_rvalid_o,
  input  wire logic                 s_axi_rready_i,
  input  wire logic [HSIS_NDIN-1:0] din_i,
  input  wire logic                 index_i,
  input  wire logic [PW-1:0]        pos_i,
  output logic                      run_o,
  output logic                      dir_o,
  output logic [31:0]               speed_o,
  output logic [PW-1:0]             home_pos_o,
  output logic                      homed_o,
  output logic                      busy_o
);

  // Byte-lane merge for partial register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  hsis_sense_if sif ();

  hsis_state_t  st;
  hsis_method_t run_meth;
  logic         run_fast;
  logic         run_dir;
  logic [31:0]  cfg;
  logic [31:0]  slow_spd;
  logic [31:0]  fast_spd;
  logic         aw_held;
  logic         w_held;
  logic [7:0]   wa;
  logic [31:0]  wd;
  logic [3:0]   ws;

  // Switch selection from configuration
  assign sif.sel = cfg[HSIS_CFG_SEL +: HSIS_SEL_W];
  assign sif.inv = cfg[HSIS_CFG_INV];

  hsis_sense u_sense (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .din_i   (din_i),
    .index_i (index_i),
    .sn      (sif.sense)
  );

  // Write channel handshakes
  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
  wire aw_fire = s_axi_awvalid_i && s_axi_awready_o;
  wire w_fire  = s_axi_wvalid_i && s_axi_wready_o;
  wire wr_do   = aw_held && w_held && !s_axi_bvalid_o;

  // Write address decode
  wire wr_ctrl = wr_do && (wa == HSIS_OFF_CTRL);
  wire wr_cfg  = wr_do && (wa == HSIS_OFF_CFG);
  wire wr_slow = wr_do && (wa == HSIS_OFF_SLOW);
  wire wr_fast = wr_do && (wa == HSIS_OFF_FAST);
  wire wr_hit  = wr_ctrl || wr_cfg || wr_slow || wr_fast ||
                 (wa == HSIS_OFF_STAT) || (wa == HSIS_OFF_HPOS);

  // Address and data capture, in either order
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      wa      <= 8'h00;
      wd      <= 32'h0000_0000;
      ws      <= 4'h0;
    end else if (ce_i) begin
      if (aw_fire) begin
        aw_held <= 1'b1;
        wa      <= s_axi_awaddr_i;
      end else if (wr_do) begin
        aw_held <= 1'b0;
      end
      if (w_fire) begin
        w_held <= 1'b1;
        wd     <= s_axi_wdata_i;
        ws     <= s_axi_wstrb_i;
      end else if (wr_do) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= HSIS_RESP_OKAY;
    end else if (ce_i) begin
      if (wr_do) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_hit ? HSIS_RESP_OKAY : HSIS_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // Configuration and speed registers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cfg      <= HSIS_CFG_RST;
      slow_spd <= HSIS_SLOW_RST;
      fast_spd <= HSIS_FAST_RST;
    end else if (ce_i) begin
      if (wr_cfg)  cfg      <= merge(cfg, wd, ws);
      if (wr_slow) slow_spd <= merge(slow_spd, wd, ws);
      if (wr_fast) fast_spd <= merge(fast_spd, wd, ws);
    end
  end

  // Read channel
  assign s_axi_arready_o = !s_axi_rvalid_o;
  wire ar_fire = s_axi_arvalid_i && s_axi_arready_o;
  wire [7:0] ra = s_axi_araddr_i;
  wire [31:0] stat_word = {25'h0, st, 2'h0, homed_o, busy_o};
  wire rd_hit = (ra == HSIS_OFF_CTRL) || (ra == HSIS_OFF_CFG) ||
                (ra == HSIS_OFF_SLOW) || (ra == HSIS_OFF_FAST) ||
                (ra == HSIS_OFF_STAT) || (ra == HSIS_OFF_HPOS);
  wire [31:0] rd_mux =
    (ra == HSIS_OFF_CFG)  ? cfg :
    (ra == HSIS_OFF_SLOW) ? slow_spd :
    (ra == HSIS_OFF_FAST) ? fast_spd :
    (ra == HSIS_OFF_STAT) ? stat_word :
    (ra == HSIS_OFF_HPOS) ? 32'(home_pos_o) : 32'h0000_0000;

  // Read data register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= HSIS_RESP_OKAY;
    end else if (ce_i) begin
      if (ar_fire) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o  <= rd_mux;
        s_axi_rresp_o  <= rd_hit ? HSIS_RESP_OKAY : HSIS_RESP_SLVERR;
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // Commands from the control register
  wire start_req = wr_ctrl && ws[0] && wd[HSIS_CTRL_START];
  wire abort_req = wr_ctrl && ws[0] && wd[HSIS_CTRL_ABORT];
  wire idle      = (st == HSIS_S_IDLE);
  wire start_ok  = start_req && idle && !abort_req;  // Abort wins
  wire cfg_abs   = cfg[HSIS_CFG_ABS];
  wire start_abs = start_ok && cfg_abs;
  wire start_mv  = start_ok && !cfg_abs;
  wire cfg_dir   = cfg[HSIS_CFG_DIR];
  wire cfg_fast  = cfg[HSIS_CFG_FAST];
  hsis_method_t cfg_meth;
  assign cfg_meth = hsis_method_t'(cfg[HSIS_CFG_METH +: 2]);

  // Target detection per phase
  wire first_tgt = (run_meth == HSIS_M_INDEX) ? sif.idx_hit
                                              : sif.sw_lvl;
  wire first_hit = (st == HSIS_S_FIRST) && first_tgt;
  wire fine_hit  = (st == HSIS_S_FINE) && sif.idx_hit;
  wire two_step  = (run_meth == HSIS_M_SW_IDX_L) ||
                   (run_meth == HSIS_M_SW_IDX_R);
  wire go_fine   = first_hit && two_step;
  wire found     = (first_hit && !two_step) || fine_hit;
  wire finish    = (found || start_abs) && !abort_req;

  // Next state and motion values
  hsis_state_t next_st;
  assign next_st = abort_req ? HSIS_S_IDLE :
                   start_mv  ? HSIS_S_FIRST :
                   go_fine   ? HSIS_S_FINE :
                   found     ? HSIS_S_IDLE : st;
  wire next_dir = start_mv ? cfg_dir :
                  go_fine  ? (run_meth == HSIS_M_SW_IDX_R) : dir_o;
  wire [31:0] next_speed =
    start_mv ? (cfg_fast ? fast_spd : slow_spd) :
    go_fine  ? slow_spd : speed_o;

  // Sequencer state and motion command
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st      <= HSIS_S_IDLE;
      run_o   <= 1'b0;
      dir_o   <= 1'b0;
      speed_o <= 32'h0000_0000;
    end else if (ce_i) begin
      st      <= next_st;
      run_o   <= (next_st != HSIS_S_IDLE);
      dir_o   <= next_dir;
      speed_o <= next_speed;
    end
  end

  // Latched run settings
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      run_meth <= HSIS_M_INDEX;
      run_fast <= 1'b0;
      run_dir  <= 1'b0;
    end else if (ce_i && start_mv) begin
      run_meth <= cfg_meth;
      run_fast <= cfg_fast;
      run_dir  <= cfg_dir;
    end
  end

  // Home position and status
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      home_pos_o <= '0;
      homed_o    <= 1'b0;
    end else if (ce_i) begin
      if (finish) begin
        home_pos_o <= pos_i;
        homed_o    <= 1'b1;
      end else if (start_mv) begin
        homed_o    <= 1'b0;
      end
    end
  end

  assign busy_o = !idle;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i || !ce_i);

  sequence s_fast_left_seek;
    st == HSIS_S_FIRST && run_meth == HSIS_M_SW_IDX_L && !dir_o &&
    speed_o == fast_spd && sif.sw_lvl && !abort_req;
  endsequence

  sequence s_slow_left_fine;
    st == HSIS_S_FINE && run_o && !dir_o && speed_o == slow_spd;
  endsequence

  a_first_dir_sel: assert property (
    start_mv && !abort_req |=> st == HSIS_S_FIRST && dir_o == $past(cfg_dir))
    else $error("first phase direction wrong");

  a_first_speed_sel: assert property (
    start_mv && !abort_req |=>
      speed_o == ($past(cfg_fast) ? $past(fast_spd) : $past(slow_spd)))
    else $error("first phase speed wrong");

  a_index_only_ignore: assert property (
    st == HSIS_S_FIRST && run_meth == HSIS_M_INDEX && !sif.idx_hit &&
    !abort_req |=> st == HSIS_S_FIRST && run_o)
    else $error("index search left phase without index");

  a_switch_only_end: assert property (
    st == HSIS_S_FIRST && run_meth == HSIS_M_SWITCH && sif.sw_lvl &&
    !abort_req |=> idle && homed_o && !run_o)
    else $error("switch search did not end on switch");

  a_fine_left_move: assert property (
    st == HSIS_S_FINE && run_meth == HSIS_M_SW_IDX_L |->
      !dir_o && speed_o == slow_spd)
    else $error("left index search not slow and left");

  a_fine_right_move: assert property (
    st == HSIS_S_FINE && run_meth == HSIS_M_SW_IDX_R |->
      dir_o && speed_o == slow_spd)
    else $error("right index search not slow and right");

  a_first_both_set: assert property (
    st == HSIS_S_FIRST |-> dir_o == run_dir &&
      speed_o == (run_fast ? fast_spd : slow_spd))
    else $error("first phase ignores initial settings");

  a_fast_left_steps: assert property (
    s_fast_left_seek |=> s_slow_left_fine)
    else $error("fast left search did not drop to slow left");

  a_abs_no_motion: assert property (
    start_abs && !abort_req |=> idle && !run_o && homed_o &&
      home_pos_o == $past(pos_i))
    else $error("absolute mode moved or missed position");

  a_done_latch_pos: assert property (
    found && !abort_req |=> !run_o && homed_o &&
      home_pos_o == $past(pos_i))
    else $error("detection did not stop and latch");

endmodule // hsis_top
`default_nettype wire

// ===== tb/hsis_far_model.sv
// Purpose: Home switch and encoder index seen from outside the drive
// Assumes: Driven from the bench on rising edges of mclk_i
// Notes:   Unselected inputs idle low; index pulse is two cycles wide
`timescale 1ns/1ps
`default_nettype none
module hsis_far_model
  import hsis_pkg::*;
(
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  input  wire logic [HSIS_SEL_W-1:0] sel_i,
  input  wire logic                  sw_on_i,
  input  wire logic                  idx_go_i,
  output logic      [HSIS_NDIN-1:0]  din_o,
  output logic                       index_o
);
  logic [1:0] idx_cnt;

  // Switch drives only the chosen digital input
  always_comb begin
    din_o        = '0;
    din_o[sel_i] = sw_on_i;
  end

  // Index pulse counter, restarted per request
  always_ff @(posedge mclk_i) begin
    if (rst_i)
      idx_cnt <= 2'h0;
    else if (idx_go_i)
      idx_cnt <= 2'h2;
    else if (idx_cnt != 2'h0)
      idx_cnt <= idx_cnt - 2'h1;
  end
  assign index_o = (idx_cnt != 2'h0);
endmodule // hsis_far_model
`default_nettype wire

// ===== tb/hsis_top_tb.sv
// Purpose: Register-driven homing scenarios for the sequencer top
// Assumes: AXI4-Lite master tasks, outputs sampled at rising edges
// Notes:   Speed registers keep reset values throughout the run
`timescale 1ns/1ps
`default_nettype none
module hsis_top_tb;
  import hsis_pkg::*;
  logic        mclk_i, rst_i;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, pos, rdata, speed, home_pos, rv;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic [7:0]  din;
  logic        index, run, dir, homed, busy, sw_on, idx_go;
  int          err_count, checked;

  // Clock at 100 MHz
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  hsis_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .din_i(din), .index_i(index),
    .pos_i(pos), .run_o(run), .dir_o(dir), .speed_o(speed),
    .home_pos_o(home_pos), .homed_o(homed), .busy_o(busy));

  hsis_far_model far (.mclk_i(mclk_i), .rst_i(rst_i), .sel_i(3'h2),
    .sw_on_i(sw_on),
    .idx_go_i(idx_go), .din_o(din), .index_o(index));

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One AXI4-Lite write, entered just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
    @(posedge mclk_i);
  endtask

  // One AXI4-Lite read
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge mclk_i);
  endtask

  // Bounded wait for the sequencer to go idle
  task automatic wait_idle;
    int n;
    for (n = 0; n < 100; n++) begin
      @(posedge mclk_i);
      if (busy === 1'b0)
        break;
    end
  endtask

  // Request one index pulse
  task automatic pulse_idx;
    idx_go <= 1'b1;
    @(posedge mclk_i);
    idx_go <= 1'b0;
  endtask

  // Full motion homing for one method and initial setup
  task automatic home(input logic [1:0] m, input logic f, input logic d,
                      input logic [31:0] p);
    logic [31:0] sp;
    sp = f ? HSIS_FAST_RST : HSIS_SLOW_RST;
    wr(HSIS_OFF_CFG, {20'h0, 1'b0, 3'h2, 3'h0, 1'b0, m, f, d});
    wr(HSIS_OFF_CTRL, 32'h0000_0001);
    chk("run", run, 1'b1);
    chk("dir", dir, d);
    chk("speed", speed, sp);
    chk("homed", homed, 1'b0);
    if (m == HSIS_M_INDEX) begin
      sw_on <= 1'b1;
      repeat (4) @(posedge mclk_i);
      chk("run", run, 1'b1);
    end
    if (m != HSIS_M_INDEX && m != HSIS_M_SWITCH) begin
      sw_on <= 1'b1;
      repeat (4) @(posedge mclk_i);
      chk("run", run, 1'b1);
      chk("speed", speed, HSIS_SLOW_RST);
      chk("dir", dir, m == HSIS_M_SW_IDX_R);
    end
    pos <= p;
    if (m == HSIS_M_SWITCH)
      sw_on <= 1'b1;
    else
      pulse_idx();
    wait_idle();
    chk("run", run, 1'b0);
    chk("homed", homed, 1'b1);
    chk("home_pos", home_pos, p);
    sw_on <= 1'b0;
    repeat (3) @(posedge mclk_i);
    $display("test method %0d done", m);
  endtask

  // Main sequence
  initial begin
    err_count = 0;
    checked = 0;
    rst_i = 1'b1;
    {awaddr, araddr, wdata, pos} = '0;
    {awvalid, wvalid, bready, arvalid, rready, sw_on, idx_go} = '0;
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    rd(HSIS_OFF_CFG, rv);
    chk("cfg", rv, HSIS_CFG_RST);
    rd(HSIS_OFF_SLOW, rv);
    chk("slow", rv, HSIS_SLOW_RST);
    rd(HSIS_OFF_FAST, rv);
    chk("fast", rv, HSIS_FAST_RST);
    rd(8'h18, rv);
    chk("rresp", resp, HSIS_RESP_SLVERR);
    wr(8'h18, 32'h0000_0001);
    chk("bresp", resp, HSIS_RESP_SLVERR);
    $display("test registers done");
    home(HSIS_M_INDEX, 1'b0, 1'b1, 32'h0000_1111);
    home(HSIS_M_SWITCH, 1'b1, 1'b0, 32'h0000_2222);
    home(HSIS_M_SW_IDX_L, 1'b1, 1'b0, 32'h0000_3333);
    home(HSIS_M_SW_IDX_R, 1'b0, 1'b1, 32'h0000_4444);
    // Switch on input 2 while input 3 is chosen: search keeps running
    sw_on <= 1'b1;
    wr(HSIS_OFF_CFG, 32'h0000_0304);
    wr(HSIS_OFF_CTRL, 32'h0000_0001);
    repeat (4) @(posedge mclk_i);
    chk("run", run, 1'b1);
    rd(HSIS_OFF_STAT, rv);
    chk("stat", rv, {25'h0, HSIS_S_FIRST, 4'h1});
    // Abort ends the search and leaves homed clear
    wr(HSIS_OFF_CTRL, 32'h0000_0002);
    chk("run", run, 1'b0);
    rd(HSIS_OFF_STAT, rv);
    chk("stat", rv, {25'h0, HSIS_S_IDLE, 4'h0});
    sw_on <= 1'b0;
    $display("test select and abort done");
    // Absolute mode: home latched at start, no motion
    pos <= 32'h0000_5555;
    wr(HSIS_OFF_CFG, 32'h0000_0010);
    wr(HSIS_OFF_CTRL, 32'h0000_0001);
    chk("homed", homed, 1'b1);
    chk("home_pos", home_pos, 32'h0000_5555);
    repeat (3) @(posedge mclk_i);
    chk("run", run, 1'b0);
    rd(HSIS_OFF_HPOS, rv);
    chk("hpos", rv, 32'h0000_5555);
    $display("test absolute done");
    // Inverted input 3 reads as switch on, search ends at once
    pos <= 32'h0000_6666;
    wr(HSIS_OFF_CFG, 32'h0000_0B04);
    wr(HSIS_OFF_CTRL, 32'h0000_0001);
    wait_idle();
    chk("run", run, 1'b0);
    chk("homed", homed, 1'b1);
    chk("home_pos", home_pos, 32'h0000_6666);
    $display("test inverted switch done");
    results();
  end

  // Watchdog
  initial begin
    #200000;
    err_count++;
    $display("watchdog expired");
    results();
  end
endmodule // hsis_top_tb
`default_nettype wire
